//--- include/dtmf_consts.svh
`ifndef DTMF_CONSTS_SVH
`define DTMF_CONSTS_SVH
// ==========================================================
// register addresses (register_select_line level)
`define DTMF_ADDR_DATA   1'b0
`define DTMF_ADDR_CTRL   1'b1
// ==========================================================
// control register a fields
`define DTMF_CTLA_TONE_EN 0
`define DTMF_CTLA_CP_MODE 1
`define DTMF_CTLA_IRQ_EN  2
`define DTMF_CTLA_NEXT_B  3
// control register b fields
`define DTMF_CTLB_BURST_N 0
`define DTMF_CTLB_TEST    1
`define DTMF_CTLB_SINGLE  2
`define DTMF_CTLB_COLUMN  3
// status register fields
`define DTMF_ST_IRQ      0
`define DTMF_ST_TXEMPTY  1
`define DTMF_ST_RXFULL   2
`define DTMF_ST_STEER    3
// ==========================================================
// reset values
`define DTMF_CTLA_RST    4'h0
`define DTMF_CTLB_RST    4'h0
`define DTMF_CODE_RST    4'h0
// ==========================================================
// timing
`define DTMF_CLK_KHZ     10000
`define DTMF_BURST_MS    51
`define DTMF_CP_BURST_MS 102
`define DTMF_CNT_W       21
`endif

//--- include/dtmf_pkg.sv
package dtmf_pkg;
  // burst sequencer phases
  typedef enum logic [1:0] {
    DTMF_BT_IDLE,
    DTMF_BT_TONE,
    DTMF_BT_PAUSE
  } dtmf_bt_st_t;

  // burst sequencer state
  typedef struct packed {
    dtmf_bt_st_t st;
    logic [20:0] cnt;
    logic        tone;
    logic        done;
  } dtmf_bt_t;

  // register bank state
  typedef struct packed {
    logic       cs_m;
    logic       cs_n_s;
    logic       wr_m;
    logic       wr_n_s;
    logic       wr_n_d;
    logic       rd_m;
    logic       rd_n_s;
    logic       rd_n_d;
    logic       rs_m;
    logic       rs_s;
    logic [3:0] d_m;
    logic [3:0] d_s;
    logic       cp_m;
    logic       cp_s;
    logic       wr_sel;
    logic       wr_rs;
    logic [3:0] wr_dat;
    logic       rd_sel;
    logic       rd_rs;
    logic [3:0] control_a;
    logic [3:0] control_b;
    logic       sel_b;
    logic [3:0] tx_code;
    logic [3:0] rx_code;
    logic       tx_empty;
    logic       rx_full;
    logic       tx_load;
    logic [3:0] dout;
    logic       doe;
    logic       ev_oe;
    logic       tone_on;
  } dtmf_rg_t;
endpackage : dtmf_pkg

//--- design/dtmf_burst_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "dtmf_consts.svh"
// ==========================================================
// burst sequencer: equal tone and pause, then a done pulse
module dtmf_burst_timer import dtmf_pkg::*; #(
  parameter logic [20:0] BURST_CYC =
    21'(`DTMF_BURST_MS * `DTMF_CLK_KHZ),
  parameter logic [20:0] LONG_CYC  =
    21'(`DTMF_CP_BURST_MS * `DTMF_CLK_KHZ)
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // control
  input  wire logic start_i,
  input  wire logic long_i,
  // status
  output logic      tone_o,
  output logic      done_o
);
  dtmf_bt_t q;
  dtmf_bt_t n;
  logic [20:0] len;

  // cp mode doubles both halves
  assign len = long_i ? LONG_CYC : BURST_CYC;

  // next state
  always_comb begin
    n      = q;
    n.done = 1'b0;
    case (q.st)
      DTMF_BT_IDLE: begin
        if (start_i) begin
          n.st   = DTMF_BT_TONE;
          n.cnt  = len - 21'h1;
          n.tone = 1'b1;
        end
      end
      DTMF_BT_TONE: begin
        if (q.cnt == 21'h0) begin
          n.st   = DTMF_BT_PAUSE;
          n.cnt  = len - 21'h1;
          n.tone = 1'b0;
        end else begin
          n.cnt = q.cnt - 21'h1;
        end
      end
      DTMF_BT_PAUSE: begin
        if (q.cnt == 21'h0) begin
          n.st   = DTMF_BT_IDLE;
          n.done = 1'b1;
        end else begin
          n.cnt = q.cnt - 21'h1;
        end
      end
      default: begin
        n = '0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tone_o = q.tone;
  assign done_o = q.done;
endmodule : dtmf_burst_timer
`default_nettype wire

//--- design/dtmf_regs.sv
// Behaviour
// - select low: write tx code, read rx code; high: control/status
// - rx data register is read only, holds last valid digit code
// - tx data register is write only, code picks the tone pair
// - a control a write with b3 set sends next control write to b, then a
// - status is read only and shows live transceiver state
// - control a b0 low forces tone output off in every mode
// - control a b1 high picks call progress, low picks dtmf mode
// - cp mode with irq enable puts squared received tone on event pin
// - no dtmf digit is detected or reported in cp mode
// - irq in dtmf mode pulls pin low on valid digit or tx ready
// - event pin is open drain, only ever pulls low
// - every access completes without wait states
// - burst mode gives tone and equal pause, 51 or 102 ms, then empty
// - test mode in dtmf mode mirrors delayed steering on event pin
// - control b b2 picks single tone, b3 then column or row
// - status b0 flags b1 or b2; status read clears b0, b1, b2
`timescale 1ns/1ns
`default_nettype none
`include "dtmf_consts.svh"
module dtmf_regs import dtmf_pkg::*; #(
  parameter logic [20:0] BURST_CYC =
    21'(`DTMF_BURST_MS * `DTMF_CLK_KHZ),
  parameter logic [20:0] LONG_CYC  =
    21'(`DTMF_CP_BURST_MS * `DTMF_CLK_KHZ)
) (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // host bus pins
  input  wire logic       chip_sel_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       register_select_line_i,
  input  wire logic [3:0] data_i,
  output logic      [3:0] data_o,
  output logic            data_oe_o,
  // event pin, open drain
  output logic            event_tone_pin_o,
  output logic            event_tone_pin_oe_o,
  // receiver datapath
  input  wire logic       rx_digit_valid_i,
  input  wire logic [3:0] rx_digit_code_i,
  input  wire logic       delayed_steer_i,
  input  wire logic       cp_tone_i,
  // transmitter datapath
  output logic      [3:0] tone_code_o,
  output logic            tone_output_enable_o,
  output logic            single_tone_o,
  output logic            column_tone_o,
  output logic            receive_mode_select_o
);
  dtmf_rg_t q;
  dtmf_rg_t n;
  logic     bt_tone;
  logic     bt_done;
  logic     burst_on;
  logic     cp_mode;
  logic     wr_end;
  logic     rd_end;
  logic     dig_ok;
  logic     st_clr;
  logic [3:0] status;

  // strobe end: synchronised level went from low to high
  function automatic logic rise(input logic prev, input logic cur);
    rise = ~prev & cur;
  endfunction : rise

  // ========================================================
  // decode helpers
  assign burst_on = ~q.control_b[`DTMF_CTLB_BURST_N];
  assign cp_mode  = q.control_a[`DTMF_CTLA_CP_MODE];
  assign wr_end   = rise(q.wr_n_d, q.wr_n_s) & q.wr_sel;
  assign rd_end   = rise(q.rd_n_d, q.rd_n_s) & q.rd_sel;
  assign dig_ok   = rx_digit_valid_i & ~cp_mode;
  assign st_clr   = rd_end & (q.rd_rs == `DTMF_ADDR_CTRL);

  // live status view
  assign status = {
    delayed_steer_i,
    q.rx_full,
    q.tx_empty,
    q.rx_full | q.tx_empty
  };

  // ========================================================
  // burst sequencer
  dtmf_burst_timer #(
    .BURST_CYC (BURST_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_burst (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .start_i (q.tx_load),
    .long_i  (cp_mode),
    .tone_o  (bt_tone),
    .done_o  (bt_done)
  );

  // ========================================================
  // next state
  always_comb begin
    n         = q;
    n.tx_load = 1'b0;
    // two flops on every bus pin and on cp tone before use
    n.cs_m   = chip_sel_n_i;
    n.cs_n_s = q.cs_m;
    n.wr_m   = wr_n_i;
    n.wr_n_s = q.wr_m;
    n.wr_n_d = q.wr_n_s;
    n.rd_m   = rd_n_i;
    n.rd_n_s = q.rd_m;
    n.rd_n_d = q.rd_n_s;
    n.rs_m   = register_select_line_i;
    n.rs_s   = q.rs_m;
    n.d_m    = data_i;
    n.d_s    = q.d_m;
    n.cp_m   = cp_tone_i;
    n.cp_s   = q.cp_m;

    // track a selected write strobe, keep last data seen
    if (~q.wr_n_s & ~q.cs_n_s) begin
      n.wr_sel = 1'b1;
      n.wr_rs  = q.rs_s;
      n.wr_dat = q.d_s;
    end else if (q.wr_n_s) begin
      n.wr_sel = 1'b0;
    end

    // track a selected read strobe
    if (~q.rd_n_s & ~q.cs_n_s) begin
      n.rd_sel = 1'b1;
      n.rd_rs  = q.rs_s;
    end else if (q.rd_n_s) begin
      n.rd_sel = 1'b0;
    end

    // commit write at strobe end
    if (wr_end) begin
      if (q.wr_rs == `DTMF_ADDR_DATA) begin
        n.tx_code = q.wr_dat;
        n.tx_load = burst_on;
        n.tx_empty = 1'b0;
      end else if (q.sel_b) begin
        n.control_b = q.wr_dat;
        n.sel_b     = 1'b0;
      end else begin
        n.control_a = q.wr_dat;
        n.sel_b     = q.wr_dat[`DTMF_CTLA_NEXT_B];
      end
    end

    // read data drive, only within the read strobe
    n.doe = ~q.cs_n_s & ~q.rd_n_s;
    if (q.rs_s == `DTMF_ADDR_DATA) begin
      n.dout = q.rx_code;
    end else begin
      n.dout = status;
    end

    // sticky flags: status read clears, a new event wins
    if (st_clr) begin
      n.tx_empty = 1'b0;
      n.rx_full  = 1'b0;
    end
    if (~burst_on) begin
      n.tx_empty = 1'b0;
    end else if (bt_done) begin
      n.tx_empty = 1'b1;
    end
    if (dig_ok) begin
      n.rx_code = rx_digit_code_i;
      n.rx_full = 1'b1;
    end

    // tone gate: needs enable bit and, in burst mode, the burst tone phase
    n.tone_on = q.control_a[`DTMF_CTLA_TONE_EN]
              & (~burst_on | bt_tone);

    // event pin pull-down
    if (~cp_mode & q.control_b[`DTMF_CTLB_TEST]) begin
      n.ev_oe = ~delayed_steer_i;
    end else if (~q.control_a[`DTMF_CTLA_IRQ_EN]) begin
      n.ev_oe = 1'b0;
    end else if (cp_mode) begin
      n.ev_oe = ~q.cp_s;
    end else begin
      n.ev_oe = n.rx_full | n.tx_empty;
    end
  end

  // ========================================================
  // state register; no documented reset pin, software must init
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q         <= '0;
      q.cs_m    <= 1'b1;
      q.cs_n_s  <= 1'b1;
      q.wr_m    <= 1'b1;
      q.wr_n_s  <= 1'b1;
      q.wr_n_d  <= 1'b1;
      q.rd_m    <= 1'b1;
      q.rd_n_s  <= 1'b1;
      q.rd_n_d  <= 1'b1;
      q.control_a <= `DTMF_CTLA_RST;
      q.control_b <= `DTMF_CTLB_RST;
      q.tx_code <= `DTMF_CODE_RST;
      q.rx_code <= `DTMF_CODE_RST;
    end else begin
      q <= n;
    end
  end

  // ========================================================
  // outputs, all straight from the state register except the event pin level, which is tied low
  assign data_o                = q.dout;
  assign data_oe_o             = q.doe;
  assign event_tone_pin_o      = 1'b0;
  assign event_tone_pin_oe_o   = q.ev_oe;
  assign tone_code_o           = q.tx_code;
  assign tone_output_enable_o  = q.tone_on;
  assign single_tone_o         = q.control_b[`DTMF_CTLB_SINGLE];
  assign column_tone_o         = q.control_b[`DTMF_CTLB_COLUMN];
  assign receive_mode_select_o = q.control_a[`DTMF_CTLA_CP_MODE];
endmodule : dtmf_regs
`default_nettype wire

//--- testbench/dtmf_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// bus and pin relations at the register bank ports
module dtmf_regs_chk (
  // watched pins
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       chip_sel_n_i,
  input wire logic       wr_n_i,
  input wire logic       rd_n_i,
  input wire logic       register_select_line_i,
  input wire logic       data_oe_o,
  input wire logic       event_tone_pin_o,
  input wire logic [3:0] tone_code_o,
  input wire logic       single_tone_o,
  input wire logic       column_tone_o,
  input wire logic       receive_mode_select_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // open drain: the pin level itself is never high
  AST_PIN_LOW: assert property (event_tone_pin_o == 1'b0)
    else $error("event pin driven high");
  AST_ANSWER: assert property ((!rd_n_i && !chip_sel_n_i) [*5] |-> data_oe_o)
    else $error("read not answered in time");
  AST_RD_IDLE: assert property (rd_n_i [*6] |-> !data_oe_o)
    else $error("bus driven without read strobe");
  AST_CS_IDLE: assert property (chip_sel_n_i [*6] |-> !data_oe_o)
    else $error("bus driven without chip select");
  AST_OE_RISE: assert property ($rose(data_oe_o) |-> !$past(rd_n_i, 2))
    else $error("bus driven before read strobe");
  AST_OE_FALL: assert property ($fell(data_oe_o) |-> $past(rd_n_i, 2) || $past(chip_sel_n_i, 2))
    else $error("bus released during read");
  // no write strobe, no register change
  AST_WR_GATE: assert property (wr_n_i [*8] |=> $stable(tone_code_o) && $stable(receive_mode_select_o) && $stable(single_tone_o) && $stable(column_tone_o))
    else $error("register changed without write");
  AST_TX_SEL: assert property (register_select_line_i [*8] |=> $stable(tone_code_o))
    else $error("tone code changed by control access");
  AST_CTRL_SEL: assert property (!register_select_line_i [*8] |=> $stable(receive_mode_select_o) && $stable(single_tone_o) && $stable(column_tone_o))
    else $error("control changed by data access");
endmodule : dtmf_regs_chk
bind dtmf_regs dtmf_regs_chk i_chk (
  .clock_i(clock_i), .rst_i(rst_i), .chip_sel_n_i(chip_sel_n_i),
  .wr_n_i(wr_n_i), .rd_n_i(rd_n_i),
  .register_select_line_i(register_select_line_i),
  .data_oe_o(data_oe_o), .event_tone_pin_o(event_tone_pin_o),
  .tone_code_o(tone_code_o), .single_tone_o(single_tone_o),
  .column_tone_o(column_tone_o),
  .receive_mode_select_o(receive_mode_select_o)
);
`default_nettype wire

//--- testbench/dtmf_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// host bus master: strobes low 5 cycles, high 5 between
module dtmf_host_model (
  // clock
  input  wire logic       clock_i,
  // bus pins toward the device
  output logic            chip_sel_n_o,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic            rs_o,
  output logic      [3:0] data_o,
  // read data from the device
  input  wire logic [3:0] rdata_i
);
  // idle bus at time zero
  initial begin
    chip_sel_n_o = 1'b1;
    wr_n_o       = 1'b1;
    rd_n_o       = 1'b1;
    rs_o         = 1'b0;
    data_o       = 4'h0;
  end
  // cs held low over the whole strobe, as the host decode does
  task automatic access(input logic wr, cs, rs,
                        input logic [3:0] d, output logic [3:0] q);
    @(posedge clock_i);
    chip_sel_n_o <= ~cs;
    rs_o         <= rs;
    data_o       <= wr ? d : ~data_o; // released bus never looks stable
    wr_n_o       <= ~wr;
    rd_n_o       <= wr;
    repeat (5) @(posedge clock_i);
    q = rdata_i;
    wr_n_o       <= 1'b1;
    rd_n_o       <= 1'b1;
    repeat (4) @(posedge clock_i);
    chip_sel_n_o <= 1'b1;
    data_o       <= ~data_o;
  endtask : access
endmodule : dtmf_host_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// register bank bench: table of writes, then hand tests
module testbench;
  typedef struct packed {
    logic       rs;
    logic [3:0] d;
    logic [7:0] exp;
  } dtmf_row_t;
  localparam logic [20:0] BURST = 21'd20;
  logic       clock_i = 1'b0;
  logic       rst_i   = 1'b1;
  logic       rx_v    = 1'b0;
  logic       steer   = 1'b0;
  logic       cp      = 1'b0;
  logic [3:0] rx_c    = 4'h0;
  logic       cs_n, wr_n, rd_n, rs, oe, ev, ev_oe, ten, sgl, col, mode;
  logic [3:0] hd, dq, code, q;
  int         bad_count = 0;
  int         checks    = 0;
  int         n         = 0;
  int         n0        = 0;
  // exp = {tone code, cp mode, single, column, tone on}
  dtmf_row_t  rows [7] = '{
    '{1'b1, 4'h8, 8'h00}, '{1'b1, 4'hd, 8'h06}, '{1'b1, 4'h2, 8'h0e},
    '{1'b1, 4'h2, 8'h0e}, '{1'b0, 4'ha, 8'hae}, '{1'b1, 4'h9, 8'ha7},
    '{1'b1, 4'h4, 8'ha4}};
  // reference driven as a buffered logic clock into the device
  always #50 clock_i = ~clock_i;
  // tone cycles counted in the background, burst starts inside a write
  always @(posedge clock_i) if (ten === 1'b1) n <= n + 1;
  dtmf_host_model i_host (
    .clock_i(clock_i), .chip_sel_n_o(cs_n), .wr_n_o(wr_n),
    .rd_n_o(rd_n), .rs_o(rs), .data_o(hd), .rdata_i(dq));
  dtmf_regs #(.BURST_CYC(BURST), .LONG_CYC(21'd40)) i_dut (
    .clock_i(clock_i), .rst_i(rst_i), .chip_sel_n_i(cs_n),
    .wr_n_i(wr_n), .rd_n_i(rd_n), .register_select_line_i(rs),
    .data_i(hd), .data_o(dq), .data_oe_o(oe),
    .event_tone_pin_o(ev), .event_tone_pin_oe_o(ev_oe),
    .rx_digit_valid_i(rx_v), .rx_digit_code_i(rx_c),
    .delayed_steer_i(steer), .cp_tone_i(cp), .tone_code_o(code),
    .tone_output_enable_o(ten), .single_tone_o(sgl),
    .column_tone_o(col), .receive_mode_select_o(mode));
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // selected write, then room for the commit to show
  task automatic wr(input logic r, input logic [3:0] d);
    i_host.access(1'b1, 1'b1, r, d, q);
    repeat (2) @(posedge clock_i);
  endtask : wr
  task automatic rd(input logic r);
    i_host.access(1'b0, 1'b1, r, 4'h0, q);
  endtask : rd
  task automatic digit(input logic [3:0] c);
    rx_v <= 1'b1;
    rx_c <= c;
    @(posedge clock_i);
    rx_v <= 1'b0;
    @(posedge clock_i);
  endtask : digit
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    check("reset", {code, mode, sgl, col, ten}, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].rs, rows[i].d);
      check("row", {code, mode, sgl, col, ten}, rows[i].exp);
    end
    i_host.access(1'b1, 1'b0, 1'b0, 4'h3, q);
    repeat (2) @(posedge clock_i);
    check("unselected write", {4'h0, code}, 8'h0a);
    rd(1'b0);
    check("rx before digit", {4'h0, q}, 8'h00);
    digit(4'h7);
    steer <= 1'b1;
    rd(1'b0);
    check("rx digit", {4'h0, q}, 8'h07);
    rd(1'b1);
    check("status", {4'h0, q}, 8'h0d);
    steer <= 1'b0;
    rd(1'b1);
    check("status cleared", {4'h0, q}, 8'h00);
    // burst with irq: tone phase length, then ready flag and pin
    wr(1'b1, 4'h5);
    n0 = n;
    wr(1'b0, 4'h3);
    repeat (60) @(posedge clock_i);
    check("burst length", 8'(n - n0), 8'(BURST));
    check("tx ready pin", {7'h0, ev_oe}, 8'h01);
    rd(1'b1);
    check("tx empty", {4'h0, q}, 8'h03);
    @(posedge clock_i);
    check("pin released", {7'h0, ev_oe}, 8'h00);
    // call progress: digits ignored, pin follows the tone
    wr(1'b1, 4'h6);
    digit(4'h9);
    rd(1'b0);
    check("cp rx code", {4'h0, q}, 8'h07);
    rd(1'b1);
    check("cp status", {4'h0, q}, 8'h00);
    check("cp pin low", {7'h0, ev_oe}, 8'h01);
    cp <= 1'b1;
    repeat (5) @(posedge clock_i);
    check("cp pin high", {7'h0, ev_oe}, 8'h00);
    // test mode: pin mirrors steering even with irq off
    wr(1'b1, 4'h8);
    wr(1'b1, 4'h2);
    check("test pin", {7'h0, ev_oe}, 8'h01);
    steer <= 1'b1;
    repeat (2) @(posedge clock_i);
    check("test pin steer", {7'h0, ev_oe}, 8'h00);
    check("ctrl b", {code, mode, sgl, col, ten}, 8'h30);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
